// [rtl/tliu_top.v]
// two-level interrupt unit: request flags, enables, priority and vectoring
//
// Functional notes
// - enable register: bit 7 global, bits 5..0 per source, bit 6 reserved.
// - global enable low: no request is acknowledged at all.
// - vectors 0000h reset, then 0003h..002Bh in steps of eight per source.
// - equal level: ext0, timer0, ext1, timer1, serial, timer2 order.
// - edge select one: falling pin edge raises the external request.
// - edge select zero: low pin level raises the external request.
// - external flag sets on condition; edge mode clears it on vectoring.
// - timer 0/1 overflow flags request, clear on vectoring; timer 0 sets none in mode 3.
// - timer 2 requests on overflow or trigger flag; neither auto-cleared.
// - falling edge on timer 2 trigger pin sets the trigger flag.
// - software set or clear of any flag acts like hardware.
// - serial done flags share one vector and stay set after vectoring.
// - on accept: core pushes return, level in-service set, jump to vector.
// - return-from-irq clears the in-service flag of its level.
// - reset clears the whole enable register.
// - priority register bits 5..0 lift a source above all clear ones.
// - enable register is bit writable without touching other bits.
`timescale 1ns/10ps
`include "tliu_map.vh"
module tliu_top (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire [7:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_bit_wr_i,
	input wire [2:0] reg_bit_sel_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	input wire ext_request_pin_0_i,
	input wire ext_request_pin_1_i,
	input wire tmr2_trigger_pin_i,
	input wire tmr0_rollover_i,
	input wire tmr1_rollover_i,
	input wire tmr2_rollover_i,
	input wire serial_rx_done_i,
	input wire serial_tx_done_i,
	output reg irq_req_o,
	output reg [15:0] irq_vector_o,
	input wire irq_ack_i,
	input wire return_from_irq_instr_i,
	output reg [1:0] in_service_o
);

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
// vector of source index n: first vector plus n steps
function [15:0] tliu_vector;
	input [2:0] idx;
	begin
		tliu_vector = `TLIU_VEC_FIRST + ({13'h0000, idx} << 3);
	end
endfunction

// merge a byte write or a single-bit write into an old value
function [7:0] tliu_merge;
	input [7:0] old;
	input [7:0] data;
	input bit_mode;
	input [2:0] sel;
	reg [7:0] msk;
	reg [7:0] val;
	begin
		msk = bit_mode ? (8'h01 << sel) : 8'hFF;
		val = bit_mode ? {8{data[0]}} : data;
		tliu_merge = (old & ~msk) | (val & msk);
	end
endfunction

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [7:0] interrupt_enable_reg;
reg [7:0] interrupt_priority_reg;
reg [7:0] ext_tmr_flags;
reg [7:0] t2_ser_flags;
reg serv_low;
reg serv_high;
reg [2:0] pend_idx;
reg pend_high;

reg [7:0] next_enable;
reg [7:0] next_prio;
reg [7:0] next_ext_tmr;
reg [7:0] next_t2_ser;
reg next_serv_low;
reg next_serv_high;
reg [7:0] next_rdata;

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
wire ext0_level;
wire ext0_fall;
wire ext1_level;
wire ext1_fall;
wire t2_trig_fall;

tliu_pin_sync u_sync_ext0 (
	.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n_i),
	.pin_i(ext_request_pin_0_i),
	.level_o(ext0_level),
	.fall_o(ext0_fall)
);

tliu_pin_sync u_sync_ext1 (
	.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n_i),
	.pin_i(ext_request_pin_1_i),
	.level_o(ext1_level),
	.fall_o(ext1_fall)
);

// pulses shorter than two clocks are filtered out; the high-plus-low
// minimum the driver must respect covers that filter with margin
tliu_pin_sync u_sync_t2 (
	.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n_i),
	.pin_i(tmr2_trigger_pin_i),
	.level_o(),
	.fall_o(t2_trig_fall)
);

// ----------------------------------------------------------------
// request vector in natural order
// ----------------------------------------------------------------
wire ext0_edge;
wire ext1_edge;
wire [5:0] src_flag;
wire [5:0] src_live;
wire [5:0] hi_req;
wire [5:0] lo_req;
wire hi_valid;
wire lo_valid;
wire [2:0] hi_idx;
wire [2:0] lo_idx;

assign ext0_edge = ext_tmr_flags[`TLIU_F_EXT0_EDGE];
assign ext1_edge = ext_tmr_flags[`TLIU_F_EXT1_EDGE];

assign src_flag[0] = ext_tmr_flags[`TLIU_F_EXT0_REQ];
assign src_flag[1] = ext_tmr_flags[`TLIU_F_TMR0_OVF];
assign src_flag[2] = ext_tmr_flags[`TLIU_F_EXT1_REQ];
assign src_flag[3] = ext_tmr_flags[`TLIU_F_TMR1_OVF];
// both serial done flags feed a single source
assign src_flag[4] = t2_ser_flags[`TLIU_F_SER_RX] | t2_ser_flags[`TLIU_F_SER_TX];
// timer 2 asks on either of its flags
assign src_flag[5] = t2_ser_flags[`TLIU_F_TMR2_OVF] | t2_ser_flags[`TLIU_F_TMR2_TRIG];

// global enable gates every source ahead of the per-source bits
assign src_live = src_flag & interrupt_enable_reg[5:0]
	& {6{interrupt_enable_reg[`TLIU_EN_GLOBAL]}};

// two levels; each level resolves its own sources by natural order
assign hi_req = src_live & interrupt_priority_reg[5:0];
assign lo_req = src_live & ~interrupt_priority_reg[5:0];

tliu_prio_pick u_pick_high (
	.req_i(hi_req),
	.valid_o(hi_valid),
	.idx_o(hi_idx)
);

tliu_prio_pick u_pick_low (
	.req_i(lo_req),
	.valid_o(lo_valid),
	.idx_o(lo_idx)
);

// ----------------------------------------------------------------
// acceptance against the level in service
// ----------------------------------------------------------------
wire hi_ok;
wire lo_ok;
wire cand_valid;
wire [2:0] cand_idx;
wire cand_high;
wire take;

// a high request only waits for a high handler; a low one waits for any
assign hi_ok = hi_valid & ~serv_high;
assign lo_ok = lo_valid & ~serv_high & ~serv_low;
assign cand_valid = hi_ok | lo_ok;
assign cand_idx = hi_ok ? hi_idx : lo_idx;
assign cand_high = hi_ok;

// the core acknowledges the offer it sees on the outputs
assign take = irq_ack_i & irq_req_o;

// ----------------------------------------------------------------
// register port decode
// ----------------------------------------------------------------
wire any_wr;
wire wr_en;
wire wr_pr;
wire wr_et;
wire wr_ts;

assign any_wr = reg_wr_i | reg_bit_wr_i;
assign wr_en = any_wr & (reg_addr_i == `TLIU_OFS_ENABLE);
assign wr_pr = any_wr & (reg_addr_i == `TLIU_OFS_PRIO);
assign wr_et = any_wr & (reg_addr_i == `TLIU_OFS_EXT_TMR);
assign wr_ts = any_wr & (reg_addr_i == `TLIU_OFS_T2_SER);

// ----------------------------------------------------------------
// next-state logic
// ----------------------------------------------------------------
always @* begin
	next_enable = interrupt_enable_reg;
	next_prio = interrupt_priority_reg;
	next_ext_tmr = ext_tmr_flags;
	next_t2_ser = t2_ser_flags;
	next_serv_low = serv_low;
	next_serv_high = serv_high;

	// single-bit writes leave every other bit alone
	if (wr_en) begin
		next_enable = tliu_merge(interrupt_enable_reg, reg_wdata_i,
			reg_bit_wr_i, reg_bit_sel_i);
	end
	next_enable[`TLIU_EN_RESERVED] = 1'b0;
	if (wr_pr) begin
		next_prio = tliu_merge(interrupt_priority_reg, reg_wdata_i,
			reg_bit_wr_i, reg_bit_sel_i) & `TLIU_SRC_MASK;
	end
	// software writes to flags act exactly as hardware would
	if (wr_et) begin
		next_ext_tmr = tliu_merge(ext_tmr_flags, reg_wdata_i,
			reg_bit_wr_i, reg_bit_sel_i) & `TLIU_EXT_TMR_MASK;
	end
	if (wr_ts) begin
		next_t2_ser = tliu_merge(t2_ser_flags, reg_wdata_i,
			reg_bit_wr_i, reg_bit_sel_i) & `TLIU_T2_SER_MASK;
	end

	// clear on vectoring: edge-mode external and timer 0/1 only
	if (take) begin
		case (pend_idx)
			3'h0: begin
				if (ext0_edge) begin
					next_ext_tmr[`TLIU_F_EXT0_REQ] = 1'b0;
				end
			end
			3'h1: begin
				next_ext_tmr[`TLIU_F_TMR0_OVF] = 1'b0;
			end
			3'h2: begin
				if (ext1_edge) begin
					next_ext_tmr[`TLIU_F_EXT1_REQ] = 1'b0;
				end
			end
			3'h3: begin
				next_ext_tmr[`TLIU_F_TMR1_OVF] = 1'b0;
			end
			// serial and timer 2 flags stay for the handler to inspect
			default: begin
				next_ext_tmr = next_ext_tmr;
			end
		endcase
		if (pend_high) begin
			next_serv_high = 1'b1;
		end else begin
			next_serv_low = 1'b1;
		end
	end

	// hardware sets come last so a set beats a same-cycle clear
	if (ext0_edge ? ext0_fall : ~ext0_level) begin
		next_ext_tmr[`TLIU_F_EXT0_REQ] = 1'b1;
	end
	if (ext1_edge ? ext1_fall : ~ext1_level) begin
		next_ext_tmr[`TLIU_F_EXT1_REQ] = 1'b1;
	end
	if (tmr0_rollover_i & ~t2_ser_flags[`TLIU_F_TMR0_MODE3]) begin
		next_ext_tmr[`TLIU_F_TMR0_OVF] = 1'b1;
	end
	if (tmr1_rollover_i) begin
		next_ext_tmr[`TLIU_F_TMR1_OVF] = 1'b1;
	end
	if (tmr2_rollover_i) begin
		next_t2_ser[`TLIU_F_TMR2_OVF] = 1'b1;
	end
	if (t2_trig_fall) begin
		next_t2_ser[`TLIU_F_TMR2_TRIG] = 1'b1;
	end
	if (serial_rx_done_i) begin
		next_t2_ser[`TLIU_F_SER_RX] = 1'b1;
	end
	if (serial_tx_done_i) begin
		next_t2_ser[`TLIU_F_SER_TX] = 1'b1;
	end

	// return ends the innermost handler, the high one when nested
	if (return_from_irq_instr_i) begin
		if (serv_high) begin
			next_serv_high = 1'b0;
		end else begin
			next_serv_low = 1'b0;
		end
	end
end

// ----------------------------------------------------------------
// read mux
// ----------------------------------------------------------------
always @* begin
	next_rdata = `TLIU_RST_BYTE;
	if (reg_rd_i) begin
		case (reg_addr_i)
			`TLIU_OFS_ENABLE: begin
				next_rdata = interrupt_enable_reg;
			end
			`TLIU_OFS_PRIO: begin
				next_rdata = interrupt_priority_reg;
			end
			`TLIU_OFS_EXT_TMR: begin
				next_rdata = ext_tmr_flags;
			end
			`TLIU_OFS_T2_SER: begin
				next_rdata = t2_ser_flags;
			end
			`TLIU_OFS_STATUS: begin
				next_rdata = {6'h00, serv_high, serv_low};
			end
			default: begin
				next_rdata = `TLIU_RST_BYTE;
			end
		endcase
	end
end

// ----------------------------------------------------------------
// state update
// ----------------------------------------------------------------
always @(posedge clk_sys_i) begin
	if (!rst_n_i) begin
		interrupt_enable_reg <= `TLIU_RST_BYTE;
		interrupt_priority_reg <= `TLIU_RST_BYTE;
		ext_tmr_flags <= `TLIU_RST_BYTE;
		t2_ser_flags <= `TLIU_RST_BYTE;
		serv_low <= 1'b0;
		serv_high <= 1'b0;
		pend_idx <= 3'h0;
		pend_high <= 1'b0;
		irq_req_o <= 1'b0;
		irq_vector_o <= `TLIU_RST_VECTOR;
		in_service_o <= 2'h0;
		reg_rdata_o <= `TLIU_RST_BYTE;
	end else begin
		interrupt_enable_reg <= next_enable;
		interrupt_priority_reg <= next_prio;
		ext_tmr_flags <= next_ext_tmr;
		t2_ser_flags <= next_t2_ser;
		serv_low <= next_serv_low;
		serv_high <= next_serv_high;
		// the offer drops right after an accept so it is not taken twice
		irq_req_o <= cand_valid & ~take;
		if (cand_valid) begin
			pend_idx <= cand_idx;
			pend_high <= cand_high;
			irq_vector_o <= tliu_vector(cand_idx);
		end
		in_service_o <= {next_serv_high, next_serv_low};
		reg_rdata_o <= next_rdata;
	end
end

endmodule

// [rtl/tliu_map.vh]
// register offsets, field positions, reset values and vector layout of the interrupt unit
`ifndef TLIU_MAP_VH
`define TLIU_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TLIU_OFS_ENABLE 8'hA8
`define TLIU_OFS_PRIO 8'hB8
`define TLIU_OFS_EXT_TMR 8'h88
`define TLIU_OFS_T2_SER 8'hC8
`define TLIU_OFS_STATUS 8'hD0

// ----------------------------------------------------------------
// enable register fields; priority register shares bits 5..0
// ----------------------------------------------------------------
`define TLIU_EN_GLOBAL 7
`define TLIU_EN_RESERVED 6
`define TLIU_SRC_MASK 8'h3F

// ----------------------------------------------------------------
// external / timer 0,1 register fields
// ----------------------------------------------------------------
`define TLIU_F_EXT0_EDGE 0
`define TLIU_F_EXT0_REQ 1
`define TLIU_F_EXT1_EDGE 2
`define TLIU_F_EXT1_REQ 3
`define TLIU_F_TMR0_OVF 5
`define TLIU_F_TMR1_OVF 7
`define TLIU_EXT_TMR_MASK 8'hAF

// ----------------------------------------------------------------
// timer 2 / serial register fields
// ----------------------------------------------------------------
`define TLIU_F_TMR2_OVF 0
`define TLIU_F_TMR2_TRIG 1
`define TLIU_F_SER_RX 2
`define TLIU_F_SER_TX 3
`define TLIU_F_TMR0_MODE3 4
`define TLIU_T2_SER_MASK 8'h1F

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define TLIU_S_SERV_LOW 0
`define TLIU_S_SERV_HIGH 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TLIU_RST_BYTE 8'h00
`define TLIU_RST_VECTOR 16'h0000

// ----------------------------------------------------------------
// vectors: first source vector and spacing between sources
// ----------------------------------------------------------------
`define TLIU_VEC_FIRST 16'h0003
`define TLIU_VEC_STEP 16'h0008

// ----------------------------------------------------------------
// timing: least edge pulse, high plus low, in oscillator periods
// ----------------------------------------------------------------
`define TLIU_EDGE_MIN_OSC 12

`endif

// [rtl/tliu_pin_sync.v]
// three-stage pin synchroniser with agreement filter and falling-edge pulse
`timescale 1ns/10ps
module tliu_pin_sync (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire pin_i,
	output reg level_o,
	output wire fall_o
);

// ----------------------------------------------------------------
// capture chain
// ----------------------------------------------------------------
reg stage1;
reg stage2;
reg stage3;

// idle level of the pins is high, so a reset never fakes an edge
always @(posedge clk_sys_i) begin
	if (!rst_n_i) begin
		stage1 <= 1'b1;
		stage2 <= 1'b1;
		stage3 <= 1'b1;
		level_o <= 1'b1;
	end else begin
		stage1 <= pin_i;
		stage2 <= stage1;
		stage3 <= stage2;
		if (stage2 == stage3) begin
			level_o <= stage3;
		end
	end
end

// a change counts only once stages two and three agree
assign fall_o = level_o & ~stage3 & ~stage2;

endmodule

// [rtl/tliu_prio_pick.v]
// fixed natural-order picker over the six maskable sources
`timescale 1ns/10ps
module tliu_prio_pick (
	input wire [5:0] req_i,
	output reg valid_o,
	output reg [2:0] idx_o
);

// ----------------------------------------------------------------
// lowest index wins
// ----------------------------------------------------------------
integer i;

always @* begin
	valid_o = 1'b0;
	idx_o = 3'h0;
	for (i = 5; i >= 0; i = i - 1) begin
		if (req_i[i]) begin
			valid_o = 1'b1;
			idx_o = i[2:0];
		end
	end
end

endmodule

// [bench/tliu_asserts.sv]
// assertion checker for the interrupt unit ports
`timescale 1ns/10ps
module tliu_asserts (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire reg_rd_i,
	input wire [7:0] reg_rdata_o,
	input wire irq_req_o,
	input wire [15:0] irq_vector_o,
	input wire irq_ack_i,
	input wire return_from_irq_instr_i,
	input wire [1:0] in_service_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);
	a_rdata_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data outside read slot");
	a_ack_drops_req: assert property (irq_req_o && irq_ack_i |=> !irq_req_o)
		else $error("offer kept after ack");
	a_ack_marks_level: assert property (irq_req_o && irq_ack_i |=> in_service_o != 2'h0)
		else $error("ack set no level");
	a_low_needs_ack: assert property ($rose(in_service_o[0]) |-> $past(irq_ack_i))
		else $error("low level set without ack");
	a_serv_steady: assert property (!irq_ack_i && !return_from_irq_instr_i |=>
		$stable(in_service_o))
		else $error("in-service moved without cause");
	a_ret_low: assert property (return_from_irq_instr_i && !irq_ack_i && in_service_o == 2'h1
		|=> in_service_o == 2'h0)
		else $error("return left low level set");
	a_ret_high_first: assert property (return_from_irq_instr_i && in_service_o == 2'h3
		|=> in_service_o == 2'h1)
		else $error("return did not drop high level first");
	a_high_blocks: assert property (in_service_o[1] |-> !irq_req_o)
		else $error("offer while high level in service");
	a_vec_form: assert property (irq_req_o |-> irq_vector_o[2:0] == 3'h3 &&
		irq_vector_o <= 16'h002B)
		else $error("vector off the table");
	cover property (irq_req_o && irq_ack_i);
	cover property (in_service_o == 2'h3);
	cover property (return_from_irq_instr_i && in_service_o[1]);
endmodule
bind tliu_top tliu_asserts u_chk (
	.clk_sys_i,
	.rst_n_i,
	.reg_rd_i,
	.reg_rdata_o,
	.irq_req_o,
	.irq_vector_o,
	.irq_ack_i,
	.return_from_irq_instr_i,
	.in_service_o
);

// [bench/tliu_core_model.sv]
// processor core stand-in: takes offered vectors and issues returns
`timescale 1ns/10ps
module tliu_core_model (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire ack_en_i,
	input wire ret_go_i,
	input wire req_i,
	input wire [15:0] vec_i,
	output reg ack_o,
	output reg ret_o,
	output reg [15:0] taken_o
);
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ack_o <= 1'b0;
			ret_o <= 1'b0;
			taken_o <= 16'h0000;
		end else begin
			// never ack twice: the offer drops only after the taking edge
			ack_o <= ack_en_i && req_i && !ack_o;
			if (ack_en_i && req_i && !ack_o) begin
				taken_o <= vec_i;
			end
			ret_o <= ret_go_i;
		end
	end
endmodule

// [bench/tb_two_level_interrupt_unit.sv]
// self-checking bench for the interrupt unit
`timescale 1ns/10ps
module tb_two_level_interrupt_unit;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0, reg_bit_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic [2:0] reg_bit_sel_i = 3'h0;
	logic ext_request_pin_0_i = 1'b1, ext_request_pin_1_i = 1'b1, tmr2_trigger_pin_i = 1'b1;
	logic tmr0_rollover_i = 1'b0, tmr1_rollover_i = 1'b0, tmr2_rollover_i = 1'b0;
	logic serial_rx_done_i = 1'b0, serial_tx_done_i = 1'b0;
	logic ack_en = 1'b0, ret_go = 1'b0;
	wire [7:0] reg_rdata_o;
	wire irq_req_o, irq_ack_i, return_from_irq_instr_i;
	wire [15:0] irq_vector_o, taken;
	wire [1:0] in_service_o;
	integer mismatches = 0, cmp_count = 0, cyc = 0;
	logic [7:0] flag_reg [6] = '{8'h88, 8'h88, 8'h88, 8'h88, 8'hC8, 8'hC8};
	logic [2:0] flag_bit [6] = '{3'h1, 3'h5, 3'h3, 3'h7, 3'h2, 3'h0};

	always #25 clk_sys_i = ~clk_sys_i;

	tliu_top dut (
		.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_bit_wr_i,
		.reg_bit_sel_i, .reg_rd_i, .reg_rdata_o, .ext_request_pin_0_i,
		.ext_request_pin_1_i, .tmr2_trigger_pin_i, .tmr0_rollover_i, .tmr1_rollover_i,
		.tmr2_rollover_i, .serial_rx_done_i, .serial_tx_done_i, .irq_req_o,
		.irq_vector_o, .irq_ack_i, .return_from_irq_instr_i, .in_service_o
	);
	tliu_core_model core (
		.clk_sys_i, .rst_n_i, .ack_en_i(ack_en), .ret_go_i(ret_go), .req_i(irq_req_o),
		.vec_i(irq_vector_o), .ack_o(irq_ack_i), .ret_o(return_from_irq_instr_i),
		.taken_o(taken)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task summarize;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task chk(input [15:0] s, input [15:0] e);
		cmp_count = cmp_count + 1;
		if (s !== e) begin
			mismatches = mismatches + 1;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask
	task bwr(input [7:0] a, input [2:0] b, input v);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_bit_sel_i <= b;
		reg_wdata_i <= {7'h00, v};
		reg_bit_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_bit_wr_i <= 1'b0;
	endtask
	task rdc(input [7:0] a, input [7:0] e);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(reg_rdata_o, e);
	endtask
	task tick(input [4:0] m);
		@(posedge clk_sys_i);
		{tmr2_rollover_i, serial_tx_done_i, serial_rx_done_i, tmr1_rollover_i,
			tmr0_rollover_i} <= m;
		@(posedge clk_sys_i);
		{tmr2_rollover_i, serial_tx_done_i, serial_rx_done_i, tmr1_rollover_i,
			tmr0_rollover_i} <= 5'h00;
	endtask
	// let the core take the next offer; the vector must stand at the ack
	task serve(input [15:0] e);
		integer n;
		repeat (2) @(posedge clk_sys_i);
		ack_en <= 1'b1;
		n = 0;
		while (irq_ack_i !== 1'b1 && n < 40) begin
			@(posedge clk_sys_i);
			#1;
			n = n + 1;
		end
		// a run-out of the wait shows up here as a missing ack
		chk(irq_ack_i, 16'h0001);
		chk(irq_vector_o, e);
		chk(taken, e);
		ack_en <= 1'b0;
		@(posedge clk_sys_i);
		#1;
	endtask
	task ret;
		@(posedge clk_sys_i);
		ret_go <= 1'b1;
		@(posedge clk_sys_i);
		ret_go <= 1'b0;
		@(posedge clk_sys_i);
		#1;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		rdc(8'hA8, 8'h00);
		rdc(8'hB8, 8'h00);
		wr(8'hA8, 8'hFF);
		rdc(8'hA8, 8'hBF);
		bwr(8'hA8, 3'h7, 1'b0);
		rdc(8'hA8, 8'h3F);
		wr(8'hB8, 8'hFF);
		rdc(8'hB8, 8'h3F);
		wr(8'hB8, 8'h00);
		rdc(8'h10, 8'h00);
	endtask
	task t_order;
		integer i;
		wr(8'h88, 8'hAA);
		wr(8'hC8, 8'h05);
		repeat (3) @(posedge clk_sys_i);
		#1;
		chk(irq_req_o, 16'h0000);
		bwr(8'hA8, 3'h7, 1'b1);
		for (i = 0; i < 6; i = i + 1) begin
			repeat (2) @(posedge clk_sys_i);
			#1;
			chk(irq_vector_o, 16'(3 + 8 * i));
			bwr(flag_reg[i], flag_bit[i], 1'b0);
		end
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk(irq_req_o, 16'h0000);
	endtask
	task t_nest;
		wr(8'hA8, 8'hA1);
		wr(8'hB8, 8'h20);
		ext_request_pin_0_i <= 1'b0;
		serve(16'h0003);
		chk(in_service_o, 16'h0001);
		@(posedge clk_sys_i);
		ext_request_pin_0_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		rdc(8'h88, 8'h02);
		chk(irq_req_o, 16'h0000);
		bwr(8'h88, 3'h1, 1'b0);
		bwr(8'hC8, 3'h0, 1'b1);
		serve(16'h002B);
		chk(in_service_o, 16'h0003);
		rdc(8'hD0, 8'h03);
		rdc(8'hC8, 8'h01);
		bwr(8'hC8, 3'h0, 1'b0);
		ret();
		chk(in_service_o, 16'h0001);
		ret();
		chk(in_service_o, 16'h0000);
		wr(8'hB8, 8'h00);
	endtask
	task t_edge;
		wr(8'hA8, 8'h84);
		wr(8'h88, 8'h04);
		ext_request_pin_1_i <= 1'b0;
		serve(16'h0013);
		@(posedge clk_sys_i);
		ext_request_pin_1_i <= 1'b1;
		rdc(8'h88, 8'h04);
		ret();
	endtask
	task t_timers;
		wr(8'hA8, 8'h8A);
		wr(8'hC8, 8'h10);
		tick(5'h01);
		rdc(8'h88, 8'h04);
		chk(irq_req_o, 16'h0000);
		wr(8'hC8, 8'h00);
		tick(5'h03);
		serve(16'h000B);
		rdc(8'h88, 8'h84);
		ret();
		serve(16'h001B);
		ret();
		rdc(8'h88, 8'h04);
	endtask
	task t_t2_serial;
		wr(8'hA8, 8'hB0);
		tmr2_trigger_pin_i <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		tick(5'h0C);
		serve(16'h0023);
		@(posedge clk_sys_i);
		tmr2_trigger_pin_i <= 1'b1;
		rdc(8'hC8, 8'h0E);
		wr(8'hC8, 8'h02);
		ret();
		serve(16'h002B);
		bwr(8'hC8, 3'h1, 1'b0);
		ret();
		// overflow path of timer 2, flag kept after vectoring
		tick(5'h10);
		serve(16'h002B);
		rdc(8'hC8, 8'h01);
		bwr(8'hC8, 3'h0, 1'b0);
		ret();
		chk(in_service_o, 16'h0000);
	endtask

	// ----------------------------------------
	// run and watchdog
	// ----------------------------------------
	always @(posedge clk_sys_i) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			mismatches = mismatches + 1;
			summarize();
		end
	end
	initial begin
		repeat (16) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		t_regs();
		t_order();
		t_nest();
		t_edge();
		t_timers();
		t_t2_serial();
		summarize();
	end
endmodule
